//--- design/dmsp_pkg.sv
// Constants, register layout and state types of the dual management slave port.
package dmsp_pkg;

  // ----------------------------------------------------------------
  // Word and field sizes
  // ----------------------------------------------------------------
  localparam int unsigned DMSP_DW = 16;
  localparam logic [4:0] DMSP_WORD_LAST = 5'h0f;
  localparam logic [4:0] DMSP_CW_LAST = 5'h07;
  localparam logic [4:0] DMSP_FLD_LAST = 5'h04;
  localparam logic [4:0] DMSP_PRE_LAST = 5'h1f;
  localparam logic [4:0] DMSP_OP_LAST = 5'h01;
  localparam logic [4:0] DMSP_TA_LAST = 5'h01;
  localparam logic [1:0] DMSP_STRAP_WAIT = 2'h3;

  // ----------------------------------------------------------------
  // Serial control word and address space
  // ----------------------------------------------------------------
  localparam int unsigned DMSP_CW_RW = 7;
  localparam int unsigned DMSP_CW_BURST = 0;
  localparam logic [5:0] DMSP_SER_WRAP = 6'h1f;
  localparam logic [5:0] DMSP_SER_ZERO = 6'h00;
  localparam logic [5:0] DMSP_SER_MATCH_OFS = 6'h3e;

  // ----------------------------------------------------------------
  // Management frame codes and register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] DMSP_OP_RD = 2'h2;
  localparam logic [1:0] DMSP_OP_WR = 2'h1;
  localparam logic [4:0] DMSP_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] DMSP_BASIC_STATUS = 5'h01;
  localparam logic [4:0] DMSP_PHY_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] DMSP_PHY_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] DMSP_AUTONEG_ADVERTISEMENT = 5'h04;
  localparam logic [4:0] DMSP_AUTONEG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] DMSP_AUTONEG_EXPANSION = 5'h06;
  localparam logic [4:0] DMSP_EXTENDED_STATUS = 5'h0f;
  localparam logic [4:0] DMSP_PAGE_SELECT = 5'h1f;
  localparam logic [1:0] DMSP_PAGE_ETH = 2'h0;
  localparam logic [1:0] DMSP_PAGE_ONE = 2'h1;

  // ----------------------------------------------------------------
  // Internal register fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned DMSP_MATCH_EN_BIT = 15;
  localparam logic [15:0] DMSP_MATCH_MASK = 16'h801f;
  localparam logic [15:0] DMSP_MATCH_RESET = 16'h0000;
  localparam int unsigned DMSP_DIS_BIT = 15;
  localparam logic [15:0] DMSP_PAGE_MASK = 16'h8003;
  localparam logic [15:0] DMSP_PAGE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DMSP_S_CTRL, DMSP_S_WR, DMSP_S_RD} dmsp_ser_t;
  typedef enum logic [3:0] {
    DMSP_M_HUNT, DMSP_M_IDLE, DMSP_M_ST, DMSP_M_OP, DMSP_M_PHY,
    DMSP_M_REG, DMSP_M_TA, DMSP_M_RDATA, DMSP_M_WDATA
  } dmsp_md_t;
  typedef enum logic [1:0] {DMSP_T_NONE, DMSP_T_ETH, DMSP_T_TIM, DMSP_T_PG} dmsp_tgt_t;

  function automatic logic dmsp_eth_impl(input logic [4:0] a);
    dmsp_eth_impl = (a == DMSP_BASIC_CONTROL) || (a == DMSP_BASIC_STATUS) ||
                    (a == DMSP_PHY_IDENTIFIER_HIGH) || (a == DMSP_PHY_IDENTIFIER_LOW) ||
                    (a == DMSP_AUTONEG_ADVERTISEMENT) || (a == DMSP_AUTONEG_PARTNER_ABILITY) ||
                    (a == DMSP_AUTONEG_EXPANSION) || (a == DMSP_EXTENDED_STATUS);
  endfunction : dmsp_eth_impl

endpackage : dmsp_pkg

//--- design/dmsp_top.sv
// Dual management slave port: four-wire serial slave and clause 22 management slave.
`timescale 1ns/1ps
`default_nettype none
module dmsp_top
  import dmsp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [3:0] strap_rxd_i,
  input wire logic strap_rx_err_i,
  output logic eth_rd_o,
  output logic eth_wr_o,
  output logic [4:0] eth_addr_o,
  output logic [15:0] eth_wdata_o,
  input wire logic [15:0] eth_rdata_i,
  output logic tim_rd_o,
  output logic tim_wr_o,
  output logic [6:0] tim_addr_o,
  output logic [15:0] tim_wdata_o,
  input wire logic [15:0] tim_rdata_i,
  output logic serial_port_disable_o,
  output logic [4:0] phy_addr_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic [1:0] mdc_s;
    logic [1:0] mdio_s;
    logic [4:0] strap_s0;
    logic [4:0] strap_s1;
    logic sclk_q;
    logic mdc_q;
    logic [1:0] strap_cnt;
    logic [4:0] phy_addr;
    dmsp_ser_t ss;
    logic [4:0] scnt;
    logic [15:0] ssh;
    logic [5:0] saddr;
    logic srw;
    logic sburst;
    logic sacc;
    logic [15:0] srd;
    logic serial_out;
    logic sdo_oe;
    logic sldp;
    dmsp_md_t ms;
    logic [4:0] mcnt;
    logic mrd;
    logic mhit;
    dmsp_tgt_t mtgt;
    logic [4:0] mphy;
    logic [15:0] msh;
    logic mo;
    logic moe;
    logic mldp;
    logic [15:0] match;
    logic [15:0] page_select;
    logic eth_rd;
    logic eth_wr;
    logic [4:0] eth_addr;
    logic [15:0] eth_wdata;
    logic tim_rd;
    logic tim_wr;
    logic [6:0] tim_addr;
    logic [15:0] tim_wdata;
  } dmsp_state_t;

  dmsp_state_t s_r;
  dmsp_state_t s_nxt;
  logic srise, sfall, mrise, sbit, mbit, dis, hit, sfetch;
  logic [7:0] cw;
  logic [15:0] word;
  logic [5:0] ainc;
  logic [1:0] op;
  logic [4:0] regad;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclk_s = {s_r.sclk_s[0], sclk_i};
    s_nxt.cs_s = {s_r.cs_s[0], cs_n_i};
    s_nxt.sdi_s = {s_r.sdi_s[0], serial_in_i};
    s_nxt.mdc_s = {s_r.mdc_s[0], mdc_i};
    s_nxt.mdio_s = {s_r.mdio_s[0], mdio_i};
    s_nxt.strap_s0 = {strap_rxd_i, strap_rx_err_i};
    s_nxt.strap_s1 = s_r.strap_s0;
    s_nxt.sclk_q = s_r.sclk_s[1];
    s_nxt.mdc_q = s_r.mdc_s[1];
    s_nxt.eth_rd = 1'b0;
    s_nxt.eth_wr = 1'b0;
    s_nxt.tim_rd = 1'b0;
    s_nxt.tim_wr = 1'b0;
    s_nxt.sldp = 1'b0;
    s_nxt.mldp = 1'b0;
    srise = s_r.sclk_s[1] & ~s_r.sclk_q;
    sfall = ~s_r.sclk_s[1] & s_r.sclk_q;
    mrise = s_r.mdc_s[1] & ~s_r.mdc_q;
    sbit = s_r.sdi_s[1];
    mbit = s_r.mdio_s[1];
    dis = s_r.page_select[DMSP_DIS_BIT];
    hit = ~s_r.match[DMSP_MATCH_EN_BIT] | (s_r.match[4:0] == s_r.phy_addr);
    cw = {s_r.ssh[6:0], sbit};
    word = {s_r.ssh[14:0], sbit};
    ainc = (s_r.saddr == DMSP_SER_WRAP) ? DMSP_SER_ZERO : s_r.saddr + 6'h01;
    sfetch = 1'b0;
    op = {s_r.msh[0], mbit};
    regad = {s_r.msh[3:0], mbit};

    // Straps are caught a few cycles after reset release.
    if (s_r.strap_cnt != DMSP_STRAP_WAIT)
    begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      s_nxt.phy_addr = s_r.strap_s1;
    end

    // ----------------------------------------------------------------
    // Four-wire serial slave, clock idle low, sample on rise
    // ----------------------------------------------------------------
    if (s_r.sldp)
    begin
      s_nxt.srd = (s_r.saddr == DMSP_SER_MATCH_OFS) ? s_r.match : tim_rdata_i;
    end
    if (s_r.cs_s[1])
    begin
      s_nxt.ss = DMSP_S_CTRL;
      s_nxt.scnt = '0;
      s_nxt.sdo_oe = 1'b0;
    end
    else if (srise)
    begin
      s_nxt.ssh = {s_r.ssh[14:0], sbit};
      s_nxt.scnt = s_r.scnt + 5'h01;
      unique case (s_r.ss)
        DMSP_S_CTRL:
        begin
          if (s_r.scnt == DMSP_CW_LAST)
          begin
            s_nxt.scnt = '0;
            s_nxt.srw = cw[DMSP_CW_RW];
            s_nxt.saddr = cw[6:1];
            s_nxt.sburst = cw[DMSP_CW_BURST];
            s_nxt.sacc = ~dis & (hit | (~cw[DMSP_CW_RW] & (cw[6:1] == DMSP_SER_MATCH_OFS)));
            s_nxt.ss = cw[DMSP_CW_RW] ? DMSP_S_RD : DMSP_S_WR;
            sfetch = cw[DMSP_CW_RW] & ~dis & hit;
          end
        end
        DMSP_S_WR:
        begin
          if (s_r.scnt == DMSP_WORD_LAST)
          begin
            s_nxt.scnt = '0;
            if (s_r.sacc && s_r.saddr == DMSP_SER_MATCH_OFS)
            begin
              s_nxt.match = word & DMSP_MATCH_MASK;
            end
            else if (s_r.sacc)
            begin
              s_nxt.tim_wr = 1'b1;
              s_nxt.tim_addr = {1'b0, s_r.saddr};
              s_nxt.tim_wdata = word;
            end
            if (s_r.sburst)
            begin
              s_nxt.saddr = ainc;
            end
            else
            begin
              s_nxt.ss = DMSP_S_CTRL;
            end
          end
        end
        DMSP_S_RD:
        begin
          if (s_r.scnt == DMSP_WORD_LAST)
          begin
            s_nxt.scnt = '0;
            if (s_r.sburst)
            begin
              s_nxt.saddr = ainc;
              sfetch = s_r.sacc;
            end
            else
            begin
              s_nxt.ss = DMSP_S_CTRL;
              s_nxt.sdo_oe = 1'b0;
            end
          end
        end
      endcase
    end
    else if (sfall && s_r.ss == DMSP_S_RD && s_r.sacc)
    begin
      s_nxt.serial_out = s_r.srd[15];
      s_nxt.srd = {s_r.srd[14:0], 1'b0};
      s_nxt.sdo_oe = 1'b1;
    end
    if (sfetch)
    begin
      s_nxt.sldp = 1'b1;
      s_nxt.tim_rd = (s_nxt.saddr != DMSP_SER_MATCH_OFS);
      s_nxt.tim_addr = {1'b0, s_nxt.saddr};
    end

    // ----------------------------------------------------------------
    // Clause 22 management slave, sample and drive on rise
    // ----------------------------------------------------------------
    if (s_r.mldp)
    begin
      unique case (s_r.mtgt)
        DMSP_T_ETH: s_nxt.msh = eth_rdata_i;
        DMSP_T_TIM: s_nxt.msh = tim_rdata_i;
        DMSP_T_PG: s_nxt.msh = s_r.page_select;
        DMSP_T_NONE: s_nxt.msh = '0;
      endcase
    end
    if (mrise)
    begin
      s_nxt.mcnt = s_r.mcnt + 5'h01;
      unique case (s_r.ms)
        DMSP_M_HUNT:
        begin
          if (!mbit)
          begin
            s_nxt.mcnt = '0;
          end
          else if (s_r.mcnt == DMSP_PRE_LAST)
          begin
            s_nxt.ms = DMSP_M_IDLE;
          end
        end
        DMSP_M_IDLE:
        begin
          if (!mbit)
          begin
            s_nxt.ms = DMSP_M_ST;
          end
          s_nxt.mcnt = '0;
        end
        DMSP_M_ST:
        begin
          s_nxt.mcnt = '0;
          s_nxt.ms = mbit ? DMSP_M_OP : DMSP_M_HUNT;
        end
        DMSP_M_OP:
        begin
          s_nxt.msh = {s_r.msh[14:0], mbit};
          if (s_r.mcnt == DMSP_OP_LAST)
          begin
            s_nxt.mcnt = '0;
            s_nxt.mrd = (op == DMSP_OP_RD);
            s_nxt.ms = (op == DMSP_OP_RD || op == DMSP_OP_WR) ? DMSP_M_PHY : DMSP_M_HUNT;
          end
        end
        DMSP_M_PHY:
        begin
          s_nxt.msh = {s_r.msh[14:0], mbit};
          if (s_r.mcnt == DMSP_FLD_LAST)
          begin
            s_nxt.mcnt = '0;
            s_nxt.mphy = regad;
            s_nxt.ms = DMSP_M_REG;
          end
        end
        DMSP_M_REG:
        begin
          s_nxt.msh = {s_r.msh[14:0], mbit};
          if (s_r.mcnt == DMSP_FLD_LAST)
          begin
            s_nxt.mcnt = '0;
            s_nxt.ms = DMSP_M_TA;
            s_nxt.mhit = (s_r.mphy == s_r.phy_addr);
            s_nxt.eth_addr = regad;
            s_nxt.tim_addr = {s_r.page_select[1:0] - DMSP_PAGE_ONE, regad};
            if (regad == DMSP_PAGE_SELECT)
            begin
              s_nxt.mtgt = DMSP_T_PG;
            end
            else if (s_r.page_select[1:0] == DMSP_PAGE_ETH && dmsp_eth_impl(regad))
            begin
              s_nxt.mtgt = DMSP_T_ETH;
            end
            else if (s_r.page_select[1:0] != DMSP_PAGE_ETH && dis)
            begin
              s_nxt.mtgt = DMSP_T_TIM;
            end
            else
            begin
              s_nxt.mtgt = DMSP_T_NONE;
            end
            if (s_r.mrd && s_r.mphy == s_r.phy_addr)
            begin
              s_nxt.mldp = 1'b1;
              s_nxt.eth_rd = (s_nxt.mtgt == DMSP_T_ETH);
              s_nxt.tim_rd = (s_nxt.mtgt == DMSP_T_TIM);
            end
          end
        end
        DMSP_M_TA:
        begin
          if (s_r.mcnt != DMSP_TA_LAST)
          begin
            s_nxt.moe = s_r.mrd & s_r.mhit;
            s_nxt.mo = 1'b0;
          end
          else
          begin
            s_nxt.mcnt = '0;
            s_nxt.ms = s_r.mrd ? DMSP_M_RDATA : DMSP_M_WDATA;
            s_nxt.mo = s_r.msh[15];
            s_nxt.msh = {s_r.msh[14:0], 1'b0};
          end
        end
        DMSP_M_RDATA:
        begin
          s_nxt.mo = s_r.msh[15];
          s_nxt.msh = {s_r.msh[14:0], 1'b0};
          if (s_r.mcnt == DMSP_WORD_LAST)
          begin
            s_nxt.mcnt = '0;
            s_nxt.moe = 1'b0;
            s_nxt.ms = DMSP_M_IDLE;
          end
        end
        DMSP_M_WDATA:
        begin
          s_nxt.msh = {s_r.msh[14:0], mbit};
          if (s_r.mcnt == DMSP_WORD_LAST)
          begin
            s_nxt.mcnt = '0;
            s_nxt.ms = DMSP_M_IDLE;
            if (s_r.mhit)
            begin
              s_nxt.eth_wr = (s_r.mtgt == DMSP_T_ETH);
              s_nxt.tim_wr = (s_r.mtgt == DMSP_T_TIM);
              s_nxt.eth_wdata = {s_r.msh[14:0], mbit};
              s_nxt.tim_wdata = {s_r.msh[14:0], mbit};
              if (s_r.mtgt == DMSP_T_PG)
              begin
                s_nxt.page_select = {s_r.msh[14:0], mbit} & DMSP_PAGE_MASK;
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The serial output enable is gated straight by the pin so that it drops without any clock.
  assign serial_out_oe_o = s_r.sdo_oe & ~cs_n_i;
  assign serial_out_o = s_r.serial_out;
  assign mdio_o = s_r.mo;
  assign mdio_oe_o = s_r.moe;
  assign eth_rd_o = s_r.eth_rd;
  assign eth_wr_o = s_r.eth_wr;
  assign eth_addr_o = s_r.eth_addr;
  assign eth_wdata_o = s_r.eth_wdata;
  assign tim_rd_o = s_r.tim_rd;
  assign tim_wr_o = s_r.tim_wr;
  assign tim_addr_o = s_r.tim_addr;
  assign tim_wdata_o = s_r.tim_wdata;
  assign serial_port_disable_o = s_r.page_select[DMSP_DIS_BIT];
  assign phy_addr_o = s_r.phy_addr;

endmodule : dmsp_top
`default_nettype wire

//--- sim/dmsp_top_assertions.sv
// Port assertions for the dual management slave port.
`timescale 1ns/1ps
`default_nettype none
module dmsp_top_assertions (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic serial_out_oe_o,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic eth_rd_o,
  input wire logic eth_wr_o,
  input wire logic [4:0] eth_addr_o,
  input wire logic tim_rd_o,
  input wire logic tim_wr_o,
  input wire logic [6:0] tim_addr_o,
  input wire logic serial_port_disable_o,
  input wire logic [4:0] phy_addr_o
);
  logic [4:0] rd_age_r;
  logic [2:0] rst_age_r;
  // Counts cycles since the last read pulse and since reset release, both saturating.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_age_r <= 5'h1f;
      rst_age_r <= 3'h0;
    end
    else
    begin
      rd_age_r <= (eth_rd_o || tim_rd_o) ? 5'h00 : rd_age_r + 5'(rd_age_r != 5'h1f);
      rst_age_r <= rst_age_r + 3'(rst_age_r != 3'h4);
    end
  end
  default clocking dmsp_cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_OE_RELEASE: assert property (cs_n_i |-> !serial_out_oe_o)
    else $error("serial output driven while deselected");
  AST_OE_DISABLED: assert property (serial_port_disable_o |-> !serial_out_oe_o)
    else $error("serial output driven while port disabled");
  AST_SER_OE_CAUSE: assert property ($rose(serial_out_oe_o) |-> rd_age_r != 5'h1f)
    else $error("serial output driven without a read");
  AST_MD_OE_CAUSE: assert property ($rose(mdio_oe_o) |-> rd_age_r != 5'h1f)
    else $error("management line driven without a read");
  AST_MD_TA_LOW: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not driven low");
  AST_MD_OE_HOLD: assert property ($rose(mdio_oe_o) |=> mdio_oe_o [*8])
    else $error("management drive dropped early");
  AST_ETH_REGS: assert property (eth_wr_o |-> eth_addr_o inside {[5'h00:5'h06], 5'h0f, 5'h1f})
    else $error("write to unimplemented management register");
  AST_TIM_SPACE: assert property ((tim_wr_o || tim_rd_o) |->
    (serial_port_disable_o ? tim_addr_o[6:5] != 2'h3 : !tim_addr_o[6]))
    else $error("timing access from the wrong port");
  AST_WR_PULSE: assert property (tim_wr_o |=> !tim_wr_o)
    else $error("timing write pulse longer than one cycle");
  AST_PHY_HOLD: assert property (rst_age_r == 3'h4 |-> $stable(phy_addr_o))
    else $error("device address changed after capture");
  cover property ($rose(serial_out_oe_o));
  cover property ($rose(mdio_oe_o));
  cover property (tim_wr_o && tim_addr_o == 7'h00);
endmodule : dmsp_top_assertions
bind dmsp_top dmsp_top_assertions i_dmsp_top_assertions (.mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .serial_out_oe_o(serial_out_oe_o), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .eth_rd_o(eth_rd_o),
  .eth_wr_o(eth_wr_o), .eth_addr_o(eth_addr_o), .tim_rd_o(tim_rd_o), .tim_wr_o(tim_wr_o),
  .tim_addr_o(tim_addr_o), .serial_port_disable_o(serial_port_disable_o), .phy_addr_o(phy_addr_o));
`default_nettype wire

//--- sim/dmsp_host_model.sv
// Bus master model for the serial and management ports.
`timescale 1ns/1ps
`default_nettype none
module dmsp_host_model (
  input wire logic clk_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  output logic mdc_o,
  output logic mdio_o,
  input wire logic md_dev_i,
  input wire logic md_oe_i
);
  logic md_host;
  // The management line has a pull-up, so a released host drives ones.
  assign mdio_o = md_oe_i ? md_dev_i : md_host;
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    mdc_o = 1'b0;
    md_host = 1'b1;
  end
  task automatic half(input int n);
    repeat (n) @(negedge clk_i);
  endtask : half
  task automatic spi(input logic [7:0] cw, input int bits, input logic [15:0] w, output logic [31:0] rd);
    logic [15:0] d;
    rd = '0;
    cs_n_o = 1'b0;
    half(4);
    for (int i = 0; i < 8 + bits; i++)
    begin
      d = w + 16'((i - 8) / 16);
      si_o = (i < 8) ? cw[7 - i] : d[(135 - i) % 16];
      half(4);
      rd = {rd[30:0], so_i};
      sclk_o = 1'b1;
      half(4);
      sclk_o = 1'b0;
    end
    half(4);
    cs_n_o = 1'b1;
    half(8);
  endtask : spi
  task automatic md(input int pre, input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                    input logic [15:0] d, output logic [16:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, phy, ra, (op == 2'b01) ? {2'b10, d} : 18'h3ffff};
    rd = '0;
    for (int i = 31 + pre; i >= 0; i--)
    begin
      md_host = f[i];
      half(6);
      rd = {rd[15:0], mdio_o};
      mdc_o = 1'b1;
      half(6);
      mdc_o = 1'b0;
    end
    md_host = 1'b1;
    half(6);
  endtask : md
endmodule : dmsp_host_model
`default_nettype wire

//--- sim/test_dmsp_top.sv
// Self-checking testbench of the dual management slave port.
`timescale 1ns/1ps
`default_nettype none
module test_dmsp_top;
  import dmsp_pkg::*;
  logic mclk, rstn, sclk, cs_n, si, so, so_oe, mdc, mdio, md_o, md_oe, eth_rd, eth_wr, tim_rd, tim_wr, dis;
  logic [4:0] eth_addr, phy;
  logic [6:0] tim_addr;
  logic [15:0] eth_wdata, tim_wdata, eth_rdata, tim_rdata;
  logic [23:0] wq[$];
  logic so_seen, md_seen;
  logic [31:0] r;
  logic [16:0] mr;
  int miscompares, samples_checked;
  assign eth_rdata = {11'h618, eth_addr};
  assign tim_rdata = {9'h12a, tim_addr};
  dmsp_top i_dmsp_top (.mclk_i(mclk), .rstn_i(rstn), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(si),
    .serial_out_o(so), .serial_out_oe_o(so_oe), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(md_o), .mdio_oe_o(md_oe),
    .strap_rxd_i(4'ha), .strap_rx_err_i(1'b1), .eth_rd_o(eth_rd), .eth_wr_o(eth_wr), .eth_addr_o(eth_addr),
    .eth_wdata_o(eth_wdata), .eth_rdata_i(eth_rdata), .tim_rd_o(tim_rd), .tim_wr_o(tim_wr),
    .tim_addr_o(tim_addr), .tim_wdata_o(tim_wdata), .tim_rdata_i(tim_rdata), .serial_port_disable_o(dis),
    .phy_addr_o(phy));
  // A released serial output shows the inverse of its last value, so a missing drive cannot pass unseen.
  dmsp_host_model i_dmsp_host_model (.clk_i(mclk), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_oe ? so : ~so),
    .mdc_o(mdc), .mdio_o(mdio), .md_dev_i(md_o), .md_oe_i(md_oe));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Logs every write pulse on the eth and tim register ports and notes any drive of either data line.
  always @(posedge mclk)
  begin
    if (tim_wr === 1'b1)
      wq.push_back({1'b0, tim_addr, tim_wdata});
    if (eth_wr === 1'b1)
      wq.push_back({3'h4, eth_addr, eth_wdata});
    if (so_oe === 1'b1)
      so_seen <= 1'b1;
    if (md_oe === 1'b1)
      md_seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w1(input logic [23:0] e);
    chk(32'(wq.size()), 32'h1);
    chk(32'(wq[0]), 32'(e));
    wq.delete();
  endtask : w1
  task automatic sp(input logic [7:0] cw, input int n, input logic [15:0] w);
    i_dmsp_host_model.spi(cw, n, w, r);
  endtask : sp
  task automatic mf(input int p, input logic [1:0] op, input logic [4:0] a, input logic [4:0] ra,
                    input logic [15:0] d);
    i_dmsp_host_model.md(p, op, a, ra, d, mr);
  endtask : mf
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic t_serial;
    chk({26'h0, dis, phy}, 32'h15);
    sp(8'h0a, 16, 16'h1234);
    w1(24'h051234);
    sp(8'h8a, 16, 16'h0);
    chk({16'h0, r[15:0]}, {16'h0, 9'h12a, 7'h05});
    sp(8'h3f, 48, 16'hbee0);
    chk(32'(wq.size()), 32'h3);
    chk({wq[0], wq[1][23:16]}, {24'h1fbee0, 8'h00});
    chk(32'(wq[2]), 32'h0001bee2);
    wq.delete();
    sp(8'hbf, 32, 16'h0);
    chk(r, {9'h12a, 7'h1f, 9'h12a, 7'h00});
    sp(8'h0a, 15, 16'h5555);
    chk(32'(wq.size()), 32'h0);
    sp(8'h0a, 16, 16'h00ff);
    w1(24'h0500ff);
    $display("t_serial done");
  endtask : t_serial
  task automatic t_match;
    sp(8'h7c, 16, 16'h8003);
    wq.delete();
    so_seen = 1'b0;
    sp(8'h0a, 16, 16'h1111);
    sp(8'h8a, 16, 16'h0);
    chk({so_seen, 31'(wq.size())}, 32'h0);
    sp(8'h7c, 16, 16'h8015);
    wq.delete();
    sp(8'h0a, 16, 16'h2222);
    w1(24'h052222);
    sp(8'h7c, 16, 16'h0000);
    wq.delete();
    sp(8'h0a, 16, 16'h3333);
    w1(24'h053333);
    $display("t_match done");
  endtask : t_match
  task automatic t_mgmt;
    mf(32, 2'b01, 5'h15, 5'h04, 16'habcd);
    w1(24'h84abcd);
    mf(1, 2'b10, 5'h15, 5'h02, 16'h0);
    chk(32'(mr), {15'h0, 1'b0, 16'hc302});
    md_seen = 1'b0;
    mf(1, 2'b01, 5'h14, 5'h00, 16'h0001);
    mf(1, 2'b10, 5'h14, 5'h00, 16'h0);
    mf(1, 2'b01, 5'h15, 5'h07, 16'h0001);
    chk({md_seen, 31'(wq.size())}, 32'h0);
    mf(32, 2'b11, 5'h15, 5'h04, 16'h0);
    mf(1, 2'b01, 5'h15, 5'h04, 16'h0f0f);
    chk(32'(wq.size()), 32'h0);
    mf(32, 2'b01, 5'h15, 5'h04, 16'h0f0f);
    w1(24'h840f0f);
    $display("t_mgmt done");
  endtask : t_mgmt
  task automatic t_page;
    mf(1, 2'b01, 5'h15, 5'h1f, 16'h8001);
    chk({31'h0, dis}, 32'h1);
    wq.delete();
    so_seen = 1'b0;
    mf(1, 2'b01, 5'h15, 5'h03, 16'h7777);
    sp(8'h0a, 16, 16'h4444);
    sp(8'h8a, 16, 16'h0);
    w1(24'h037777);
    chk({31'h0, so_seen}, 32'h0);
    mf(1, 2'b01, 5'h15, 5'h1f, 16'h0000);
    chk({31'h0, dis}, 32'h0);
    $display("t_page done");
  endtask : t_page
  initial
  begin
    rstn = 1'b0;
    so_seen = 1'b0;
    md_seen = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    repeat (6) @(negedge mclk);
    t_serial;
    t_match;
    t_mgmt;
    t_page;
    test_done;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    chk(32'h0, 32'h1);
    test_done;
  end
endmodule : test_dmsp_top
`default_nettype wire
